// file: shared/rfo_pkg.sv
// Constants, field layouts and carrier types for the receive overhead status bank.
// Assumes one framer port per bank instance, fed by that port's synchronizer on hclk.
//
// Operation
// RULE_01 - Far-end error A count is 16 bits: high byte first, low byte next.
// RULE_02 - Far-end error B count is 16 bits: high byte first, low byte next.
// RULE_03 - Monitor register holds the byte of the channel chosen by the monitor select.
// RULE_04 - Monitor byte: last received bit in bit 0, first in bit 7.
// RULE_05 - T1 link register reports link or signaling-frame bits, earliest bit in bit 0.
// RULE_06 - D4 framing: link register updates on multiframe boundaries, six bits in 5:0.
// RULE_07 - Last valid six-bit bit-oriented code sits in bits 5:0, upper bits zero.
// RULE_08 - E1 mode: link address returns live CRC-4 synchronizer status instead.
// RULE_09 - Sync counter increments each time an 8 ms CRC-4 search expires.
// RULE_10 - Sync counter clears on CRC-4 sync or when CRC-4 mode is off.
// RULE_11 - Sync counter is 6 bits, saturates; bits 5:2 and 0 shown in 7:3.
// RULE_12 - Host should give up the CRC-4 search after 400 ms without sync.
// RULE_13 - Live bits: 2 CRC-4 search, 1 CAS search, 0 frame alignment search.
// RULE_14 - T1 mode: three registers capture the SLC-96 data link fields.
// RULE_15 - E1 align-frame register: international bit on 7, alignment pattern on 6:0.
// RULE_16 - E1 non-align register: international, one, remote alarm, spare bits four..eight.
// RULE_17 - E1 register gathers international bits of even align frames 14..0 in 7:0.
// RULE_18 - Port n sits at base plus 200h*(n-1) plus 2000h per full group of eight.
// RULE_19 - T1 or E1 mode picks the register definition at shared offsets 062h..066h.
// RULE_20 - Bank registers are read-only; writes never disturb captures or counters.

package rfo_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_FEA_HI    = 16'h0058;
  localparam logic [15:0] OFF_FEA_LO    = 16'h0059;
  localparam logic [15:0] OFF_FEB_HI    = 16'h005A;
  localparam logic [15:0] OFF_FEB_LO    = 16'h005B;
  localparam logic [15:0] OFF_DS0       = 16'h0060;
  localparam logic [15:0] OFF_LINK      = 16'h0062;
  localparam logic [15:0] OFF_BOC       = 16'h0063;
  localparam logic [15:0] OFF_SLC1      = 16'h0064;
  localparam logic [15:0] OFF_SLC2      = 16'h0065;
  localparam logic [15:0] OFF_SLC3      = 16'h0066;
  localparam logic [15:0] OFF_CTRL      = 16'h0070;
  localparam logic [15:0] PORT_STRIDE   = 16'h0200;
  localparam logic [15:0] GROUP_STRIDE  = 16'h2000;
  localparam int          GROUP_PORTS   = 8;
  localparam int          NUM_PORTS     = 16;

  // ----------------------------------------------------------------
  // Control register fields and fixed patterns
  // ----------------------------------------------------------------
  localparam int          CTRL_E1_BIT   = 0;
  localparam int          CTRL_D4_BIT   = 1;
  localparam int          CTRL_CRC4_BIT = 3;
  localparam int          CTRL_SEL_LSB  = 8;
  localparam logic [6:0]  FAS_PATTERN   = 7'h1B;
  localparam logic [5:0]  CSC_MAX       = 6'h3F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          SEARCH_MS     = 8;
  localparam int          SEARCH_CYCLES = SEARCH_MS * (CLK_HZ / 1000);
  localparam int          TMR_W         = 19;

  // ----------------------------------------------------------------
  // Synchronizer feed for one port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        fea_err;
    logic        feb_err;
    logic        ch_valid;
    logic [4:0]  ch_num;
    logic [2:0]  ch_pos;
    logic        ch_bit;
    logic        link_valid;
    logic        link_bit;
    logic        mf_boundary;
    logic        boc_valid;
    logic [5:0]  boc_code;
    logic        crc_sync_ok;
    logic        crc_search;
    logic        cas_search;
    logic        fas_search;
    logic        slc_valid;
    logic [10:0] slc_c;
    logic [2:0]  slc_m;
    logic [1:0]  slc_a;
    logic [3:0]  slc_s;
    logic        fas_valid;
    logic        fas_si;
    logic [3:0]  fas_frame;
    logic        nfas_valid;
    logic        nfas_si;
    logic        nfas_alarm;
    logic [4:0]  nfas_spare;
  } rfo_feed_t;

  // ----------------------------------------------------------------
  // Whole state of the bank
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]      fe_a;
    logic [15:0]      fe_b;
    logic [7:0]       ds0_sh;
    logic [7:0]       ds0;
    logic [7:0]       link_sh;
    logic [2:0]       link_cnt;
    logic [7:0]       link;
    logic [5:0]       bit_oriented_code;
    logic [5:0]       crc_sync_search_count;
    logic [TMR_W-1:0] tmr;
    logic [2:0]       rt;
    logic [7:0]       slc1;
    logic [7:0]       slc2;
    logic [7:0]       slc3;
    logic [7:0]       raf;
    logic [7:0]       rnaf;
    logic [7:0]       rsiaf;
    logic             e1_mode;
    logic             d4_mode;
    logic             crc4_en;
    logic [4:0]       mon_sel;
    logic             wr_pend;
    logic [31:0]      hrdata;
  } rfo_state_t;

  localparam rfo_state_t STATE_RESET = '0;

endpackage

// file: rtl/rfo_status_bank.sv
// Receive overhead status bank of one framer port, an AHB-Lite slave.
// Assumes the feed is synchronous to hclk and the master issues single word transfers.
//
// The implementer's own choice: the AHB-Lite slave port.

`timescale 1ns/10ps

module rfo_status_bank #(
  parameter int          PORT_NUM      = 1,
  parameter int unsigned SEARCH_CYCLES = rfo_pkg::SEARCH_CYCLES
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire rfo_pkg::rfo_feed_t feed
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PORT_NUM < 1 || PORT_NUM > rfo_pkg::NUM_PORTS)
  begin : g_bad_port
    $error("port number out of range");
  end
  if (SEARCH_CYCLES < 1 || SEARCH_CYCLES > (1 << rfo_pkg::TMR_W))
  begin : g_bad_timer
    $error("search period does not fit the timer");
  end

  // Port window base, in register index units
  localparam logic [15:0] PORT_BASE = 16'(rfo_pkg::PORT_STRIDE * (PORT_NUM - 1)
      + rfo_pkg::GROUP_STRIDE * ((PORT_NUM - 1) / rfo_pkg::GROUP_PORTS)); // [RULE_18]
  localparam logic [rfo_pkg::TMR_W-1:0] TMR_LAST = rfo_pkg::TMR_W'(SEARCH_CYCLES - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Saturating increment keeps a stuck source from wrapping a count to zero
  function automatic logic [15:0] sat_inc16(input logic [15:0] v);
    sat_inc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // Byte presented at a local offset; mode picks the shared definitions
  function automatic logic [7:0] reg_read(input rfo_pkg::rfo_state_t s,
                                          input logic [15:0] off);
    reg_read = 8'h00;
    case (off)
      rfo_pkg::OFF_FEA_HI: reg_read = s.fe_a[15:8]; // [RULE_01]
      rfo_pkg::OFF_FEA_LO: reg_read = s.fe_a[7:0];
      rfo_pkg::OFF_FEB_HI: reg_read = s.fe_b[15:8]; // [RULE_02]
      rfo_pkg::OFF_FEB_LO: reg_read = s.fe_b[7:0];
      rfo_pkg::OFF_DS0:    reg_read = s.ds0;
      rfo_pkg::OFF_LINK:   reg_read = s.e1_mode ? {s.crc_sync_search_count[5:2], s.crc_sync_search_count[0], s.rt}
                                                : s.link; // [RULE_08] [RULE_11] [RULE_19]
      rfo_pkg::OFF_BOC:    reg_read = s.e1_mode ? 8'h00 : {2'b00, s.bit_oriented_code}; // [RULE_07]
      rfo_pkg::OFF_SLC1:   reg_read = s.e1_mode ? s.raf : s.slc1;    // [RULE_19]
      rfo_pkg::OFF_SLC2:   reg_read = s.e1_mode ? s.rnaf : s.slc2;
      rfo_pkg::OFF_SLC3:   reg_read = s.e1_mode ? s.rsiaf : s.slc3;
      rfo_pkg::OFF_CTRL:   reg_read = 8'h00;
      default:             reg_read = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rfo_pkg::rfo_state_t st_ff;
  rfo_pkg::rfo_state_t nxt_st;

  logic [15:0] reg_idx;
  logic [15:0] loc_off;
  logic        in_window;
  logic        take;
  logic        crc_count_on;
  logic        crc_tick;
  logic [7:0]  ds0_shift;
  logic [7:0]  link_shift;

  // Address decode of the address phase
  assign reg_idx   = haddr[17:2];
  assign loc_off   = reg_idx - PORT_BASE;
  assign in_window = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00)
                     && (reg_idx >= PORT_BASE) && (loc_off < rfo_pkg::PORT_STRIDE); // [RULE_18]
  assign take      = hsel && htrans[1] && hready;

  // Search timer runs only while CRC-4 alignment is hunted in E1
  assign crc_count_on = st_ff.e1_mode && st_ff.crc4_en && feed.crc_search
                        && !feed.crc_sync_ok;
  assign crc_tick     = crc_count_on && (st_ff.tmr == TMR_LAST); // [RULE_09]

  // Shift values including the bit arriving this cycle
  assign ds0_shift  = {st_ff.ds0_sh[6:0], feed.ch_bit}; // [RULE_04]
  assign link_shift = st_ff.d4_mode ? {2'b00, feed.link_bit, st_ff.link_sh[5:1]}
                                    : {feed.link_bit, st_ff.link_sh[7:1]}; // [RULE_05]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;

    // Far-end error counts move only on their events, never on writes
    if (feed.fea_err)
      nxt_st.fe_a = sat_inc16(st_ff.fe_a); // [RULE_01] [RULE_20]
    if (feed.feb_err)
      nxt_st.fe_b = sat_inc16(st_ff.fe_b); // [RULE_02] [RULE_20]

    // Monitored channel: shift first bit toward bit 7, latch on the eighth
    if (feed.ch_valid && (feed.ch_num == st_ff.mon_sel))
    begin
      nxt_st.ds0_sh = ds0_shift;
      if (feed.ch_pos == 3'h7)
        nxt_st.ds0 = ds0_shift; // [RULE_03] [RULE_04]
    end

    // T1 link bits: earliest bit lands in bit 0
    if (feed.link_valid)
    begin
      nxt_st.link_sh  = link_shift;
      nxt_st.link_cnt = st_ff.link_cnt + 3'h1;
      if (!st_ff.d4_mode && (st_ff.link_cnt == 3'h7))
        nxt_st.link = link_shift; // [RULE_05]
    end
    // D4 signaling-frame bits are published only at the multiframe edge
    if (st_ff.d4_mode && feed.mf_boundary)
    begin
      nxt_st.link     = feed.link_valid ? link_shift : {2'b00, st_ff.link_sh[5:0]}; // [RULE_06]
      nxt_st.link_cnt = 3'h0;
    end

    if (feed.boc_valid)
      nxt_st.bit_oriented_code = feed.boc_code; // [RULE_07]

    // CRC-4 search timer and saturating sync counter
    if (!st_ff.crc4_en || feed.crc_sync_ok)
    begin
      nxt_st.crc_sync_search_count = 6'h00; // [RULE_10]
      nxt_st.tmr = '0;
    end
    else if (crc_count_on)
    begin
      nxt_st.tmr = crc_tick ? '0 : st_ff.tmr + 1'b1;
      if (crc_tick && (st_ff.crc_sync_search_count != rfo_pkg::CSC_MAX))
        nxt_st.crc_sync_search_count = st_ff.crc_sync_search_count + 6'h01; // [RULE_09] [RULE_11]
    end
    else
      nxt_st.tmr = '0;

    // Live search flags, sampled once so reads see a clean value
    nxt_st.rt = {feed.crc_search, feed.cas_search, feed.fas_search}; // [RULE_13]

    // SLC-96 data link capture
    if (feed.slc_valid)
    begin
      nxt_st.slc1 = feed.slc_c[7:0]; // [RULE_14]
      nxt_st.slc2 = {feed.slc_m[1:0], 3'b010, feed.slc_c[10:8]};
      nxt_st.slc3 = {1'b1, feed.slc_s, feed.slc_a, feed.slc_m[2]};
    end

    // E1 align and non-align frame captures
    if (feed.fas_valid)
    begin
      nxt_st.raf = {feed.fas_si, rfo_pkg::FAS_PATTERN}; // [RULE_15]
      if (!feed.fas_frame[0])
        nxt_st.rsiaf[feed.fas_frame[3:1]] = feed.fas_si; // [RULE_17]
    end
    if (feed.nfas_valid)
      nxt_st.rnaf = {feed.nfas_si, 1'b1, feed.nfas_alarm, feed.nfas_spare}; // [RULE_16]

    // Bus: only the control word accepts writes; bank registers ignore them
    nxt_st.wr_pend = 1'b0;
    if (st_ff.wr_pend)
    begin
      nxt_st.e1_mode = hwdata[rfo_pkg::CTRL_E1_BIT];
      nxt_st.d4_mode = hwdata[rfo_pkg::CTRL_D4_BIT];
      nxt_st.crc4_en = hwdata[rfo_pkg::CTRL_CRC4_BIT];
      nxt_st.mon_sel = hwdata[rfo_pkg::CTRL_SEL_LSB +: 5];
    end
    if (take)
    begin
      nxt_st.wr_pend = hwrite && in_window && (loc_off == rfo_pkg::OFF_CTRL); // [RULE_20]
      if (!hwrite && in_window)
      begin
        if (loc_off == rfo_pkg::OFF_CTRL)
          nxt_st.hrdata = {19'h0_0000, st_ff.mon_sel, 4'h0, st_ff.crc4_en, 1'b0,
                           st_ff.d4_mode, st_ff.e1_mode};
        else
          nxt_st.hrdata = {24'h00_0000, reg_read(st_ff, loc_off)};
      end
      else
        nxt_st.hrdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_ff <= rfo_pkg::STATE_RESET;
    else
      st_ff <= nxt_st;
  end

  // Zero wait state slave; OKAY only, so hresp is tied low; hreadyout is a flop held low in reset
  logic hreadyout_ff;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout_ff <= 1'b0;
    else
      hreadyout_ff <= 1'b1;
  end

  assign hrdata    = st_ff.hrdata;
  assign hreadyout = hreadyout_ff;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Byte the host sees at the code offset, watched for its two zero top bits
  logic [7:0] boc_byte;
  assign boc_byte = reg_read(st_ff, rfo_pkg::OFF_BOC);

  sequence s_search_expiry;
    crc_count_on && (st_ff.tmr == TMR_LAST);
  endsequence

  sequence s_link_read_e1;
    take && !hwrite && in_window && (loc_off == rfo_pkg::OFF_LINK) && st_ff.e1_mode;
  endsequence

  chk_csc_increment: assert property ( // [RULE_09]
    s_search_expiry ##0 (st_ff.crc_sync_search_count < rfo_pkg::CSC_MAX) |=> st_ff.crc_sync_search_count == $past(st_ff.crc_sync_search_count) + 6'h01)
    else $error("sync counter missed a search expiry");

  chk_csc_saturate: assert property ( // [RULE_11]
    (st_ff.crc_sync_search_count == rfo_pkg::CSC_MAX) && st_ff.crc4_en && !feed.crc_sync_ok
    |=> st_ff.crc_sync_search_count == rfo_pkg::CSC_MAX)
    else $error("sync counter wrapped");

  chk_csc_clear: assert property ( // [RULE_10]
    (!st_ff.crc4_en || feed.crc_sync_ok) |=> st_ff.crc_sync_search_count == 6'h00)
    else $error("sync counter not cleared");

  chk_csc_period: assert property ( // [RULE_09]
    $changed(st_ff.crc_sync_search_count) && (st_ff.crc_sync_search_count != 6'h00) |-> $past(st_ff.tmr) == TMR_LAST)
    else $error("sync counter moved before the search period ended");

  chk_link_e1_read: assert property ( // [RULE_08]
    s_link_read_e1 |=> st_ff.hrdata[7:0] == {$past(st_ff.crc_sync_search_count[5:2]), $past(st_ff.crc_sync_search_count[0]),
                                            $past(st_ff.rt)})
    else $error("link address did not return live sync status in E1");

  chk_d4_update: assert property ( // [RULE_06]
    st_ff.d4_mode && $past(st_ff.d4_mode) && $changed(st_ff.link) |-> $past(feed.mf_boundary))
    else $error("D4 link register moved off a multiframe boundary");

  chk_boc_capture: assert property ( // [RULE_07]
    feed.boc_valid |=> (st_ff.bit_oriented_code == $past(feed.boc_code)) ##1 (boc_byte[7:6] == 2'b00))
    else $error("bit-oriented code not held");

  chk_si_even_slot: assert property ( // [RULE_17]
    feed.fas_valid && !feed.fas_frame[0]
    |=> st_ff.rsiaf[$past(feed.fas_frame[3:1])] == $past(feed.fas_si))
    else $error("align frame international bit in the wrong slot");

  chk_slc_fixed: assert property ( // [RULE_14]
    feed.slc_valid |=> (st_ff.slc2[5:3] == 3'b010) && st_ff.slc3[7]
                       && (st_ff.slc1 == $past(feed.slc_c[7:0])))
    else $error("data link capture fixed bits wrong");

  chk_align_pattern: assert property ( // [RULE_15]
    feed.fas_valid |=> st_ff.raf == {$past(feed.fas_si), rfo_pkg::FAS_PATTERN})
    else $error("align frame register pattern wrong");

  chk_nonalign_fixed: assert property ( // [RULE_16]
    feed.nfas_valid |=> st_ff.rnaf[6] && (st_ff.rnaf[4:0] == $past(feed.nfas_spare)))
    else $error("non-align frame register layout wrong");

  chk_count_write_safe: assert property ( // [RULE_20]
    st_ff.wr_pend && !feed.fea_err |=> st_ff.fe_a == $past(st_ff.fe_a))
    else $error("write disturbed error count");

  chk_ds0_latch: assert property ( // [RULE_03]
    feed.ch_valid && (feed.ch_num == st_ff.mon_sel) && (feed.ch_pos == 3'h7)
    |=> st_ff.ds0[0] == $past(feed.ch_bit))
    else $error("monitor byte did not take its last bit in bit 0");

endmodule

// file: test/rfo_host_model.sv
// Host side model: an AHB-Lite master making single word transfers.
// Assumes one slave whose hreadyout is fed back as the bus hready.
`timescale 1ns/10ps

module rfo_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             hang
);
  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
    hang   = 1'b0;
  end

  // Bounded wait for hready; a stuck slave raises hang instead of hanging
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 64)
      hang <= 1'b1;
  endtask

  // One transfer; each phase is held until hready is sampled high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~a;  // Released address and data never keep the last value
    hwdata <= wd;
    wait_rdy();
    hwdata <= ~wd;
  endtask
endmodule

// file: test/tb_rfo_status_bank.sv
// Self-checking bench of the receive overhead status bank of port 10.
// Assumes the host model as bus master and the bench as synchronizer feed.
`timescale 1ns/10ps

module tb_rfo_status_bank;
  localparam int          PN   = 10;
  localparam int          SRCH = 20;
  localparam logic [31:0] BASE = 32'h0000_0200 * (PN - 1) + 32'h0000_2000 * ((PN - 1) / 8);

  logic               hclk = 1'b0;
  logic               hresetn;
  logic               hsel;
  logic               hwrite;
  logic               hreadyout;
  logic               hresp;
  logic               hang;
  logic               rd_ph = 1'b0;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic [15:0]        seed;
  logic [15:0]        na;
  logic [15:0]        nb;
  rfo_pkg::rfo_feed_t fd;
  rfo_pkg::rfo_feed_t p;
  logic [31:0]        exp_q[$];
  logic [31:0]        adr_q[$];
  int                 n_fail = 0;
  int                 n_checks = 0;

  // ----------------------------------------------------------------
  // Clock, instances, helpers
  // ----------------------------------------------------------------
  always #10 hclk = ~hclk;

  rfo_status_bank #(.PORT_NUM(PN), .SEARCH_CYCLES(SRCH)) rfo_status_bank_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .feed(fd));

  rfo_host_model rfo_host_model_inst (
    .hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hB400) : (s >> 1);
  endfunction

  // Byte address of a register index in this port
  function automatic logic [31:0] ad(input logic [15:0] idx);
    return (BASE + {16'h0000, idx}) << 2;
  endfunction

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] a, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error reg at %h expected %h seen %h", a, exp, got);
    end
  endtask

  // Reads note their expectation; the watcher compares it later
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    adr_q.push_back(a);
    rfo_host_model_inst.xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    rfo_host_model_inst.xfer(1'b1, a, d);
  endtask

  // One-cycle feed pulse, then the feed goes quiet
  task automatic pls(input rfo_pkg::rfo_feed_t f);
    @(posedge hclk);
    fd <= f;
    @(posedge hclk);
    fd <= '0;
  endtask

  task automatic send_link(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      p = '0;
      p.link_valid = 1'b1;
      p.link_bit = b[i];
      pls(p);
    end
  endtask

  // Oldest note is taken when a read data phase completes
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout === 1'b1)
    begin
      check(adr_q.pop_front(), hrdata, exp_q.pop_front());
      check(32'hFFFF_FFFF, 32'(hresp), 32'h0000_0000);
    end
    rd_ph <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
  end

  // A hung transfer counts as a mismatch and ends the run
  always @(posedge hang)
  begin
    n_fail++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    fd = '0;
    p = '0;
    seed = 16'h004C;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    // Reset values in T1 mode
    for (int i = 0; i < 4; i++)
      rd(ad(16'h0058 + 16'(i)), 8'h00);
    rd(ad(16'h0062), 8'h00);
    rd(ad(16'h0063), 8'h00);
    // Far-end A count past one byte, B count below it, pulsed together
    seed = lfsr(seed);
    na = 16'h0100 + {10'h000, seed[5:0]};
    nb = {8'h00, ~seed[7:0]};
    for (int i = 0; i < na; i++)
    begin
      p = '0;
      p.fea_err = 1'b1;
      p.feb_err = (i < nb);
      pls(p);
    end
    rd(ad(16'h0058), na[15:8]);
    rd(ad(16'h0059), na[7:0]);
    rd(ad(16'h005A), nb[15:8]);
    rd(ad(16'h005B), nb[7:0]);
    wr(ad(16'h0059), 32'hFFFF_FFFF);
    rd(ad(16'h0059), na[7:0]);
    rd(32'h0000_0160, 8'h00);
    // Monitor channel 5 while channel 6 interleaves
    wr(ad(16'h0070), 32'h0000_0500);
    seed = lfsr(seed);
    for (int i = 0; i < 8; i++)
    begin
      p = '0;
      p.ch_valid = 1'b1;
      p.ch_num = 5'd5;
      p.ch_pos = i[2:0];
      p.ch_bit = seed[7 - i];
      pls(p);
      p.ch_num = 5'd6;
      p.ch_bit = ~seed[7 - i];
      pls(p);
    end
    rd(ad(16'h0060), seed[7:0]);
    // Link bits: ESF byte, then D4 on multiframe edges only
    seed = lfsr(seed);
    send_link(seed[7:0], 8);
    rd(ad(16'h0062), seed[7:0]);
    wr(ad(16'h0070), 32'h0000_0502);
    send_link(~seed[7:0], 6);
    p = '0;
    p.mf_boundary = 1'b1;
    pls(p);
    rd(ad(16'h0062), {2'b00, ~seed[5:0]});
    send_link(seed[7:0], 3);
    rd(ad(16'h0062), {2'b00, ~seed[5:0]});
    // Only a validated code is kept
    p = '0;
    p.boc_valid = 1'b1;
    p.boc_code = seed[13:8];
    pls(p);
    p.boc_valid = 1'b0;
    p.boc_code = ~seed[13:8];
    pls(p);
    rd(ad(16'h0063), {2'b00, seed[13:8]});
    // SLC-96 capture
    seed = lfsr(seed);
    p = '0;
    p.slc_valid = 1'b1;
    p.slc_c = {seed[2:0], seed[15:8]};
    p.slc_m = seed[5:3];
    p.slc_a = seed[7:6];
    p.slc_s = seed[11:8];
    pls(p);
    rd(ad(16'h0064), p.slc_c[7:0]);
    rd(ad(16'h0065), {p.slc_m[1:0], 3'b010, p.slc_c[10:8]});
    rd(ad(16'h0066), {1'b1, p.slc_s, p.slc_a, p.slc_m[2]});
    // E1 mode: align and non-align captures at the shared offsets
    wr(ad(16'h0070), 32'h0000_0001);
    seed = lfsr(seed);
    for (int i = 0; i < 8; i++)
    begin
      p = '0;
      p.fas_valid = 1'b1;
      p.fas_si = seed[i];
      p.fas_frame = 4'(2 * i);
      pls(p);
    end
    rd(ad(16'h0064), {seed[7], 7'h1B});
    rd(ad(16'h0066), seed[7:0]);
    p = '0;
    p.nfas_valid = 1'b1;
    p.nfas_si = seed[8];
    p.nfas_alarm = seed[9];
    p.nfas_spare = seed[14:10];
    pls(p);
    rd(ad(16'h0065), {seed[8], 1'b1, seed[9], seed[14:10]});
    rd(ad(16'h0063), 8'h00);
    // CRC-4 search: count five periods, then saturate
    wr(ad(16'h0070), 32'h0000_0009);
    p = '0;
    p.crc_search = 1'b1;
    p.cas_search = 1'b1;
    @(posedge hclk);
    fd <= p;
    repeat (108) @(posedge hclk);
    rd(ad(16'h0062), 8'h1E);
    repeat (1400) @(posedge hclk);
    rd(ad(16'h0062), 8'hFE);
    // Past the give-up point the host acts; here the synchronizer is forced into sync
    p = '0;
    p.crc_sync_ok = 1'b1;
    p.fas_search = 1'b1;
    @(posedge hclk);
    fd <= p;
    repeat (3) @(posedge hclk);
    rd(ad(16'h0062), 8'h01);
    // Count three periods, then clear by turning CRC-4 off
    p = '0;
    p.crc_search = 1'b1;
    @(posedge hclk);
    fd <= p;
    repeat (65) @(posedge hclk);
    rd(ad(16'h0062), 8'h0C);
    wr(ad(16'h0070), 32'h0000_0001);
    rd(ad(16'h0062), 8'h04);
    rd(ad(16'h0070), 8'h01);
    repeat (4) @(posedge hclk);
    report_and_stop();
  end
endmodule
